// ### hdl/spcfg_defines.svh
`ifndef SPCFG_DEFINES_SVH
`define SPCFG_DEFINES_SVH

// Register offsets on the host processor port
`define SPCFG_OFS_LEVEL_SEL    18'h30920
`define SPCFG_OFS_MAIN_REPEAT  18'h30921
`define SPCFG_OFS_MAIN_LEN_HI  18'h30922
`define SPCFG_OFS_MAIN_LEN_LO  18'h30923
`define SPCFG_OFS_SHD_REPEAT   18'h30924
`define SPCFG_OFS_SHD_LEN_HI   18'h30925
`define SPCFG_OFS_SHD_LEN_LO   18'h30926
`define SPCFG_OFS_VFIFO_COUNT  18'h30927
`define SPCFG_OFS_AGGR_WIDTH   18'h30930

// Status memory window, addresses 0 to 255
`define SPCFG_STAT_MEM_LAST    18'h000ff

// Reset values
`define SPCFG_RST_BYTE         8'h00

// Field positions (bit 0 on the bus is the least significant bit)
`define SPCFG_FULL_PICK_MSB    7
`define SPCFG_FULL_PICK_LSB    4
`define SPCFG_EMPTY_PICK_MSB   3
`define SPCFG_EMPTY_PICK_LSB   0
`define SPCFG_LEN_HI_MSB       1
`define SPCFG_LEN_HI_LSB       0
`define SPCFG_STAT_MSB         1
`define SPCFG_STAT_LSB         0

// Calendar memory layout
`define SPCFG_MAIN_CAL_BASE    11'h000
`define SPCFG_SHD_CAL_BASE     11'h400

// Lines in one buffer bank, each line 128 data bits
`define SPCFG_BANK_LINES       9'h100

`endif

// ### hdl/spcfg_pkg.sv
package spcfg_pkg;

    // Two-bit field codes of one bank
    typedef logic [1:0] spcfg_code_t;

    // Aggregation width codes
    typedef enum logic [1:0] {
        SPCFG_AGGR_32,
        SPCFG_AGGR_64,
        SPCFG_AGGR_128,
        SPCFG_AGGR_BAD
    } spcfg_aggr_e;

    // Read path source
    typedef enum logic [1:0] {
        SPCFG_RSRC_NONE,
        SPCFG_RSRC_REG,
        SPCFG_RSRC_MEM
    } spcfg_rsrc_e;

    // Virtual FIFO count: 00 one, 01 two, 10 four, 11 eight
    function automatic logic [3:0] spcfg_vfifo_count(spcfg_code_t code);
        spcfg_vfifo_count = 4'h1 << code;
    endfunction

    // Field of bank b where bank 0 sits in the top two bits
    function automatic spcfg_code_t spcfg_bank_code(logic [7:0] r,
                                                    int unsigned b);
        spcfg_bank_code = r[7 - 2 * b -: 2];
    endfunction

endpackage

// ### hdl/spcfg_status_mem.sv
`include "spcfg_defines.svh"

module spcfg_status_mem
    import spcfg_pkg::*;
(
    input  wire logic       clk,       // System clock
    input  wire logic       rst_b,     // Asynchronous reset, active low
    input  wire logic       wr_en,     // Host write strobe
    input  wire logic [7:0] wr_idx,    // Host write index
    input  wire logic [1:0] wr_data,   // Status value to store
    input  wire logic [7:0] rd_idx_a,  // Host read index
    output logic      [1:0] rd_data_a, // Host read value
    input  wire logic [7:0] rd_idx_b,  // Core read index
    output logic      [1:0] rd_data_b  // Core read value
);

    logic [1:0] mem_reg  [256];
    logic [1:0] mem_next [256];

    // Next contents: one entry written per strobe
    always_comb begin
        mem_next = mem_reg;
        if (wr_en) begin
            mem_next[wr_idx] = wr_data;
        end
    end

    // Entry storage
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < 256; i++) begin
                mem_reg[i] <= 2'h0;
            end
        end else begin
            mem_reg <= mem_next;
        end
    end

    assign rd_data_a = mem_reg[rd_idx_a];
    assign rd_data_b = mem_reg[rd_idx_b];

endmodule

// ### hdl/spcfg_level_calc.sv
`include "spcfg_defines.svh"

module spcfg_level_calc
    import spcfg_pkg::*;
(
    input  wire logic [1:0] vfifo_code,  // Virtual FIFO count code
    input  wire logic       full_pick,   // Full level select
    input  wire logic       empty_pick,  // Empty level select
    output logic      [8:0] part_lines,  // Lines in one partition
    output logic      [8:0] full_level,  // Lines at which full is declared
    output logic      [8:0] empty_level  // Lines at which empty is declared
);

    logic [10:0] three_q;

    // Partition size in 128-bit lines, whatever the aggregation width
    always_comb begin
        part_lines  = `SPCFG_BANK_LINES >> vfifo_code;
        three_q     = 11'(part_lines) * 11'h003;
        full_level  = full_pick ? 9'(three_q[10:2] + 9'h001) : part_lines;
        empty_level = empty_pick ? 9'((part_lines >> 2) - 9'h001) : 9'h000;
    end

endmodule

// ### hdl/spcfg_top.sv
// Overview of operation
// - With the status memory select set, host accesses to addresses 0-255 reach the status memory.
// - The status memory has 256 entries, each six unused upper bits and a two-bit status value.
// - One full pick bit per send bank: zero means truly full, one means three quarters of lines plus one.
// - One empty pick bit per receive bank: zero means truly empty, one means a quarter of lines minus one.
// - The level picks hold in every aggregation width and lines are always 128 data bits.
// - An eight-bit count sets main calendar repeats between framing patterns.
// - The main calendar length is ten bits, its top two in one register and the low eight in the next.
// - An eight-bit count sets shadow calendar repeats between framing patterns.
// - The shadow calendar length is split the same way over two registers.
// - Each bank's two-bit code gives one, two, four or eight virtual queues.
// - The queue count codes of banks 0 to 3 sit from the top of one register downward.
// - Each bank's two-bit code gives 32, 64 or 128-bit grouping, and code 11 is invalid.
// - The grouping codes of banks 0 to 3 sit from the top of one register downward.
// - Calendar memory spans 0-2047 with main in the lower and shadow in the upper half.
`include "spcfg_defines.svh"

module spcfg_top
    import spcfg_pkg::*;
(
    input  wire logic        clk,                  // System clock, 10 MHz
    input  wire logic        rst_b,                // Async reset, active low
    input  wire logic [17:0] hpp_addr,             // Host port address
    input  wire logic [7:0]  hpp_wdata,            // Host port write data
    input  wire logic        hpp_wr,               // Host write strobe
    input  wire logic        hpp_rd,               // Host read strobe
    input  wire logic        stat_mem_select,      // Status memory window on
    output logic      [7:0]  hpp_rdata,            // Host read data
    output logic             hpp_rvalid,           // Read data valid pulse
    input  wire logic [7:0]  stat_idx,             // Core status index
    output logic      [1:0]  stat_value,           // Core status value
    output logic      [3:0]  send_bank_full_level_pick,     // Per bank
    output logic      [3:0]  receive_bank_empty_level_pick, // Per bank
    output logic      [35:0] bank_full_level,      // 9 bits per bank
    output logic      [35:0] bank_empty_level,     // 9 bits per bank
    output logic      [15:0] bank_queue_count,     // 4 bits per bank
    output logic      [7:0]  bank_width_grouping,  // 2 bits per bank
    output logic      [3:0]  bank_width_invalid,   // Code 11 flags
    output logic      [7:0]  primary_sequence_repeat_count,   // Main
    output logic      [9:0]  primary_sequence_length,         // Main
    output logic      [7:0]  alternate_sequence_repeat_count, // Shadow
    output logic      [9:0]  alternate_sequence_length,       // Shadow
    output logic      [10:0] primary_calendar_last_addr,      // Main end
    output logic      [10:0] alternate_calendar_last_addr     // Shadow end
);

    // Configuration registers
    logic [7:0] level_sel_reg,   level_sel_next;
    logic [7:0] main_rep_reg,    main_rep_next;
    logic [1:0] main_len_hi_reg, main_len_hi_next;
    logic [7:0] main_len_lo_reg, main_len_lo_next;
    logic [7:0] shd_rep_reg,     shd_rep_next;
    logic [1:0] shd_len_hi_reg,  shd_len_hi_next;
    logic [7:0] shd_len_lo_reg,  shd_len_lo_next;
    logic [7:0] vfifo_reg,       vfifo_next;
    logic [7:0] aggr_reg,        aggr_next;

    // Read path
    logic [7:0]  rdata_reg,  rdata_next;
    logic        rvalid_reg, rvalid_next;
    logic [1:0]  stat_reg,   stat_next;
    spcfg_rsrc_e rsrc;
    logic [7:0]  reg_rd_val;

    // Derived outputs
    logic [35:0] full_lvl_reg,  full_lvl_next;
    logic [35:0] empty_lvl_reg, empty_lvl_next;
    logic [15:0] qcnt_reg,      qcnt_next;
    logic [3:0]  inval_reg,     inval_next;
    logic [10:0] main_last_reg, main_last_next;
    logic [10:0] shd_last_reg,  shd_last_next;

    logic        mem_hit;
    logic [1:0]  mem_rd_a;
    logic [1:0]  mem_rd_b;
    logic [35:0] lvl_full_w;
    logic [35:0] lvl_empty_w;
    logic [9:0]  main_len;
    logic [9:0]  shd_len;

    assign main_len = {main_len_hi_reg, main_len_lo_reg};
    assign shd_len  = {shd_len_hi_reg, shd_len_lo_reg};

    // Low window goes to the status memory only while selected
    assign mem_hit = stat_mem_select &&
                     (hpp_addr <= `SPCFG_STAT_MEM_LAST);

    // Status memory, 256 two-bit entries
    spcfg_status_mem u_stat_mem (
        .clk       (clk),
        .rst_b     (rst_b),
        .wr_en     (hpp_wr && mem_hit),
        .wr_idx    (hpp_addr[7:0]),
        .wr_data   (hpp_wdata[`SPCFG_STAT_MSB:`SPCFG_STAT_LSB]),
        .rd_idx_a  (hpp_addr[7:0]),
        .rd_data_a (mem_rd_a),
        .rd_idx_b  (stat_idx),
        .rd_data_b (mem_rd_b)
    );

    // Level thresholds per bank
    for (genvar b = 0; b < 4; b++) begin : g_bank
        spcfg_level_calc u_lvl (
            .vfifo_code  (spcfg_bank_code(vfifo_reg, b)),
            .full_pick   (level_sel_reg[`SPCFG_FULL_PICK_MSB - b]),
            .empty_pick  (level_sel_reg[`SPCFG_EMPTY_PICK_MSB - b]),
            .part_lines  (),
            .full_level  (lvl_full_w[9 * b +: 9]),
            .empty_level (lvl_empty_w[9 * b +: 9])
        );
    end

    // Register writes from the host port
    always_comb begin
        level_sel_next   = level_sel_reg;
        main_rep_next    = main_rep_reg;
        main_len_hi_next = main_len_hi_reg;
        main_len_lo_next = main_len_lo_reg;
        shd_rep_next     = shd_rep_reg;
        shd_len_hi_next  = shd_len_hi_reg;
        shd_len_lo_next  = shd_len_lo_reg;
        vfifo_next       = vfifo_reg;
        aggr_next        = aggr_reg;
        if (hpp_wr && !mem_hit) begin
            case (hpp_addr)
                `SPCFG_OFS_LEVEL_SEL:   level_sel_next = hpp_wdata;
                `SPCFG_OFS_MAIN_REPEAT: main_rep_next = hpp_wdata;
                `SPCFG_OFS_MAIN_LEN_HI: main_len_hi_next =
                    hpp_wdata[`SPCFG_LEN_HI_MSB:`SPCFG_LEN_HI_LSB];
                `SPCFG_OFS_MAIN_LEN_LO: main_len_lo_next = hpp_wdata;
                `SPCFG_OFS_SHD_REPEAT:  shd_rep_next = hpp_wdata;
                `SPCFG_OFS_SHD_LEN_HI:  shd_len_hi_next =
                    hpp_wdata[`SPCFG_LEN_HI_MSB:`SPCFG_LEN_HI_LSB];
                `SPCFG_OFS_SHD_LEN_LO:  shd_len_lo_next = hpp_wdata;
                `SPCFG_OFS_VFIFO_COUNT: vfifo_next = hpp_wdata;
                `SPCFG_OFS_AGGR_WIDTH:  aggr_next = hpp_wdata;
                default: ;
            endcase
        end
    end

    // Configuration storage, all clearing to zero
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            level_sel_reg   <= `SPCFG_RST_BYTE;
            main_rep_reg    <= `SPCFG_RST_BYTE;
            main_len_hi_reg <= 2'h0;
            main_len_lo_reg <= `SPCFG_RST_BYTE;
            shd_rep_reg     <= `SPCFG_RST_BYTE;
            shd_len_hi_reg  <= 2'h0;
            shd_len_lo_reg  <= `SPCFG_RST_BYTE;
            vfifo_reg       <= `SPCFG_RST_BYTE;
            aggr_reg        <= `SPCFG_RST_BYTE;
        end else begin
            level_sel_reg   <= level_sel_next;
            main_rep_reg    <= main_rep_next;
            main_len_hi_reg <= main_len_hi_next;
            main_len_lo_reg <= main_len_lo_next;
            shd_rep_reg     <= shd_rep_next;
            shd_len_hi_reg  <= shd_len_hi_next;
            shd_len_lo_reg  <= shd_len_lo_next;
            vfifo_reg       <= vfifo_next;
            aggr_reg        <= aggr_next;
        end
    end

    // Register readback, reserved bits as zero
    always_comb begin
        reg_rd_val = 8'h00;
        rsrc       = SPCFG_RSRC_REG;
        case (hpp_addr)
            `SPCFG_OFS_LEVEL_SEL:   reg_rd_val = level_sel_reg;
            `SPCFG_OFS_MAIN_REPEAT: reg_rd_val = main_rep_reg;
            `SPCFG_OFS_MAIN_LEN_HI: reg_rd_val = {6'h00, main_len_hi_reg};
            `SPCFG_OFS_MAIN_LEN_LO: reg_rd_val = main_len_lo_reg;
            `SPCFG_OFS_SHD_REPEAT:  reg_rd_val = shd_rep_reg;
            `SPCFG_OFS_SHD_LEN_HI:  reg_rd_val = {6'h00, shd_len_hi_reg};
            `SPCFG_OFS_SHD_LEN_LO:  reg_rd_val = shd_len_lo_reg;
            `SPCFG_OFS_VFIFO_COUNT: reg_rd_val = vfifo_reg;
            `SPCFG_OFS_AGGR_WIDTH:  reg_rd_val = aggr_reg;
            default:                rsrc = SPCFG_RSRC_NONE;
        endcase
        if (mem_hit) begin
            rsrc = SPCFG_RSRC_MEM;
        end
    end

    // Read data and core status lookup
    always_comb begin
        rvalid_next = hpp_rd;
        rdata_next  = rdata_reg;
        stat_next   = mem_rd_b;
        if (hpp_rd) begin
            case (rsrc)
                SPCFG_RSRC_MEM:  rdata_next = {6'h00, mem_rd_a};
                SPCFG_RSRC_REG:  rdata_next = reg_rd_val;
                SPCFG_RSRC_NONE: rdata_next = 8'h00;
                default:         rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_reg  <= 8'h00;
            rvalid_reg <= 1'b0;
            stat_reg   <= 2'h0;
        end else begin
            rdata_reg  <= rdata_next;
            rvalid_reg <= rvalid_next;
            stat_reg   <= stat_next;
        end
    end

    // Decoded bank settings and calendar spans
    always_comb begin
        full_lvl_next  = lvl_full_w;
        empty_lvl_next = lvl_empty_w;
        for (int b = 0; b < 4; b++) begin
            qcnt_next[4 * b +: 4] =
                spcfg_vfifo_count(spcfg_bank_code(vfifo_reg, b));
            inval_next[b] =
                (spcfg_bank_code(aggr_reg, b) == SPCFG_AGGR_BAD);
        end
        main_last_next = `SPCFG_MAIN_CAL_BASE;
        shd_last_next  = `SPCFG_SHD_CAL_BASE;
        if (main_len != 10'h000) begin
            main_last_next = `SPCFG_MAIN_CAL_BASE + 11'(main_len - 10'h001);
        end
        if (shd_len != 10'h000) begin
            shd_last_next = `SPCFG_SHD_CAL_BASE + 11'(shd_len - 10'h001);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            full_lvl_reg  <= 36'h0;
            empty_lvl_reg <= 36'h0;
            qcnt_reg      <= 16'h0;
            inval_reg     <= 4'h0;
            main_last_reg <= `SPCFG_MAIN_CAL_BASE;
            // Shadow span starts in its own half, even straight out of reset
            shd_last_reg  <= `SPCFG_SHD_CAL_BASE;
        end else begin
            full_lvl_reg  <= full_lvl_next;
            empty_lvl_reg <= empty_lvl_next;
            qcnt_reg      <= qcnt_next;
            inval_reg     <= inval_next;
            main_last_reg <= main_last_next;
            shd_last_reg  <= shd_last_next;
        end
    end

    // Outputs straight from flip-flops
    assign hpp_rdata  = rdata_reg;
    assign hpp_rvalid = rvalid_reg;
    assign stat_value = stat_reg;
    assign send_bank_full_level_pick =
        level_sel_reg[`SPCFG_FULL_PICK_MSB:`SPCFG_FULL_PICK_LSB];
    assign receive_bank_empty_level_pick =
        level_sel_reg[`SPCFG_EMPTY_PICK_MSB:`SPCFG_EMPTY_PICK_LSB];
    assign bank_full_level                 = full_lvl_reg;
    assign bank_empty_level                = empty_lvl_reg;
    assign bank_queue_count                = qcnt_reg;
    assign bank_width_grouping             = aggr_reg;
    assign bank_width_invalid              = inval_reg;
    assign primary_sequence_repeat_count   = main_rep_reg;
    assign primary_sequence_length         = main_len;
    assign alternate_sequence_repeat_count = shd_rep_reg;
    assign alternate_sequence_length       = shd_len;
    assign primary_calendar_last_addr      = main_last_reg;
    assign alternate_calendar_last_addr    = shd_last_reg;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_mem_write;
        hpp_wr && stat_mem_select && (hpp_addr <= `SPCFG_STAT_MEM_LAST);
    endsequence

    sequence s_same_read;
        hpp_rd && stat_mem_select && !hpp_wr &&
        (hpp_addr == $past(hpp_addr));
    endsequence

    AST_MEM_ROUNDTRIP: assert property (
        s_mem_write ##1 s_same_read |=>
        hpp_rdata == {6'h00, $past(hpp_wdata[1:0], 2)})
        else $error("Status memory read back differs from write");

    AST_MEM_UPPER_ZERO: assert property (
        hpp_rd && mem_hit |=> hpp_rvalid && hpp_rdata[7:2] == 6'h00)
        else $error("Status entry upper bits not zero");

    AST_FULL_LEVEL: assert property (
        send_bank_full_level_pick[3] && bank_queue_count[3:0] == 4'h8
        && $stable(level_sel_reg) && $stable(vfifo_reg)
        |-> bank_full_level[8:0] == 9'd25)
        else $error("Full level for 32 lines is not 25");

    AST_EMPTY_LEVEL: assert property (
        receive_bank_empty_level_pick[3] && bank_queue_count[3:0] == 4'h8
        && $stable(level_sel_reg) && $stable(vfifo_reg)
        |-> bank_empty_level[8:0] == 9'd7)
        else $error("Empty level for 32 lines is not 7");

    AST_MAIN_REPEAT: assert property (
        hpp_wr && !mem_hit && hpp_addr == `SPCFG_OFS_MAIN_REPEAT |=>
        primary_sequence_repeat_count == $past(hpp_wdata))
        else $error("Main repeat count not taken");

    AST_MAIN_LENGTH: assert property (
        hpp_wr && !mem_hit && hpp_addr == `SPCFG_OFS_MAIN_LEN_HI |=>
        primary_sequence_length[9:8] == $past(hpp_wdata[1:0]))
        else $error("Main length upper bits not taken");

    AST_SHD_LENGTH: assert property (
        hpp_wr && !mem_hit && hpp_addr == `SPCFG_OFS_SHD_LEN_LO |=>
        alternate_sequence_length[7:0] == $past(hpp_wdata))
        else $error("Shadow length lower bits not taken");

    AST_QUEUE_COUNT: assert property (
        hpp_wr && !mem_hit && hpp_addr == `SPCFG_OFS_VFIFO_COUNT
        && hpp_wdata[7:6] == 2'h3 ##1 !hpp_wr |=>
        bank_queue_count[3:0] == 4'h8)
        else $error("Bank 0 queue count code 11 not eight");

    AST_WIDTH_INVALID: assert property (
        hpp_wr && !mem_hit && hpp_addr == `SPCFG_OFS_AGGR_WIDTH ##1 !hpp_wr
        |=> bank_width_invalid[0] == ($past(hpp_wdata[7:6], 2) == 2'h3))
        else $error("Invalid grouping flag wrong for bank 0");

    AST_SHADOW_HALF: assert property (
        alternate_calendar_last_addr[10] && !primary_calendar_last_addr[10])
        else $error("Calendar span left its half");

endmodule

// ### verification/tb.sv
`include "spcfg_defines.svh"

module tb
    import spcfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk = 1'b0;
    logic        rst_b;
    logic [17:0] hpp_addr;
    logic [7:0]  hpp_wdata;
    logic        hpp_wr;
    logic        hpp_rd;
    logic        stat_mem_select;
    logic [7:0]  hpp_rdata;
    logic        hpp_rvalid;
    logic [7:0]  stat_idx;
    logic [1:0]  stat_value;
    logic [3:0]  full_pick;
    logic [3:0]  empty_pick;
    logic [35:0] full_lvl;
    logic [35:0] empty_lvl;
    logic [15:0] qcnt;
    logic [7:0]  grouping;
    logic [3:0]  invalid;
    logic [7:0]  m_rep;
    logic [9:0]  m_len;
    logic [7:0]  s_rep;
    logic [9:0]  s_len;
    logic [10:0] m_last;
    logic [10:0] s_last;
    int          num_errors = 0;
    int          checks_done = 0;
    integer      seed = 82476;
    logic [7:0]  v [9];
    logic [17:0] ofs [9] = '{`SPCFG_OFS_LEVEL_SEL, `SPCFG_OFS_MAIN_REPEAT,
        `SPCFG_OFS_MAIN_LEN_HI, `SPCFG_OFS_MAIN_LEN_LO, `SPCFG_OFS_SHD_REPEAT,
        `SPCFG_OFS_SHD_LEN_HI, `SPCFG_OFS_SHD_LEN_LO, `SPCFG_OFS_VFIFO_COUNT,
        `SPCFG_OFS_AGGR_WIDTH};

    // Clock, 100 ns period
    always #50 clk = ~clk;

    spcfg_top dut_u (
        .clk(clk), .rst_b(rst_b), .hpp_addr(hpp_addr), .hpp_wdata(hpp_wdata),
        .hpp_wr(hpp_wr), .hpp_rd(hpp_rd), .stat_mem_select(stat_mem_select),
        .hpp_rdata(hpp_rdata), .hpp_rvalid(hpp_rvalid), .stat_idx(stat_idx),
        .stat_value(stat_value), .send_bank_full_level_pick(full_pick),
        .receive_bank_empty_level_pick(empty_pick),
        .bank_full_level(full_lvl), .bank_empty_level(empty_lvl),
        .bank_queue_count(qcnt), .bank_width_grouping(grouping),
        .bank_width_invalid(invalid), .primary_sequence_repeat_count(m_rep),
        .primary_sequence_length(m_len),
        .alternate_sequence_repeat_count(s_rep),
        .alternate_sequence_length(s_len),
        .primary_calendar_last_addr(m_last),
        .alternate_calendar_last_addr(s_last));

    // Partition lines of bank b from the queue count register
    function automatic logic [8:0] lines(logic [7:0] q, int b);
        return 9'h100 >> q[7 - 2 * b -: 2];
    endfunction

    // Expected full and empty levels, queue counts and invalid flags
    function automatic logic [35:0] exp_lvl(logic [7:0] s, logic [7:0] q,
                                            logic full);
        logic [35:0] r;
        r = '0;
        for (int b = 0; b < 4; b++) begin
            if (full) begin
                r[9 * b +: 9] = s[7 - b] ? (lines(q, b) >> 2) * 3 + 9'h001
                                         : lines(q, b);
            end else begin
                r[9 * b +: 9] = s[3 - b] ? (lines(q, b) >> 2) - 9'h001
                                         : 9'h000;
            end
        end
        return r;
    endfunction

    function automatic logic [15:0] exp_q(logic [7:0] q);
        logic [15:0] r;
        for (int b = 0; b < 4; b++) begin
            r[4 * b +: 4] = 4'h1 << q[7 - 2 * b -: 2];
        end
        return r;
    endfunction

    function automatic logic [3:0] exp_inv(logic [7:0] a);
        logic [3:0] r;
        for (int b = 0; b < 4; b++) begin
            r[b] = (a[7 - 2 * b -: 2] == 2'h3);
        end
        return r;
    endfunction

    function automatic logic [10:0] exp_last(logic [9:0] n, logic [10:0] base);
        return (n == 10'h000) ? base : base + {1'b0, n} - 11'h001;
    endfunction

    // Compare of host read data
    task automatic chk_rd(logic [7:0] got, logic [7:0] exp, string msg);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // Compare of a configuration output
    task automatic chk_out(logic [35:0] got, logic [35:0] exp, string msg);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // One host write cycle
    task automatic wr(logic [17:0] a, logic [7:0] d);
        @(negedge clk);
        hpp_addr = a;
        hpp_wdata = d;
        hpp_wr = 1'b1;
        @(negedge clk);
        hpp_wr = 1'b0;
    endtask

    // One host read cycle, data valid one cycle later
    task automatic rd(logic [17:0] a, logic [7:0] exp, string msg);
        @(negedge clk);
        hpp_addr = a;
        hpp_rd = 1'b1;
        @(negedge clk);
        hpp_rd = 1'b0;
        chk_out(hpp_rvalid, 36'h1, "read valid");
        chk_rd(hpp_rdata, exp, msg);
        @(negedge clk);
        chk_out(hpp_rvalid, 36'h0, "read valid one cycle");
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        #(20000 * 100);
        num_errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        tally_and_finish();
    end

    // Main sequence
    initial begin
        logic [7:0] i8;
        logic [1:0] d2;
        {rst_b, hpp_addr, hpp_wdata, hpp_wr, hpp_rd} = '0;
        {stat_mem_select, stat_idx} = '0;
        repeat (16) @(posedge clk);
        @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        chk_out(full_lvl, {4{9'h100}}, "reset full level");
        chk_out(empty_lvl, 36'h0, "reset empty level");
        chk_out(s_last, 36'h400, "reset shadow end");
        for (int i = 0; i < 9; i++) rd(ofs[i], 8'h00, "reset value");
        $display("test reset done");
        for (int t = 0; t < 14; t++) begin
            for (int i = 0; i < 9; i++) begin
                v[i] = (t == 0) ? 8'hff : (t == 1) ? 8'h00 : 8'($random(seed));
                wr(ofs[i], v[i]);
            end
            for (int i = 0; i < 9; i++) begin
                i8 = (i == 2 || i == 5) ? (v[i] & 8'h03) : v[i];
                rd(ofs[i], i8, "register readback");
            end
            chk_out(full_pick, v[0][7:4], "fp");
            chk_out(empty_pick, v[0][3:0], "ep");
            chk_out(full_lvl, exp_lvl(v[0], v[7], 1'b1), "full");
            chk_out(empty_lvl, exp_lvl(v[0], v[7], 1'b0), "empty");
            chk_out(qcnt, exp_q(v[7]), "queue count");
            chk_out(grouping, v[8], "grouping");
            chk_out(invalid, exp_inv(v[8]), "invalid code");
            chk_out(m_rep, v[1], "main repeat");
            chk_out(s_rep, v[4], "shadow repeat");
            chk_out(m_len, {v[2][1:0], v[3]}, "main length");
            chk_out(s_len, {v[5][1:0], v[6]}, "shadow length");
            chk_out(m_last, exp_last({v[2][1:0], v[3]}, 11'h000),
                    "main end");
            chk_out(s_last, exp_last({v[5][1:0], v[6]}, 11'h400),
                    "shadow end");
        end
        $display("test config done");
        for (int t = 0; t < 10; t++) begin
            i8 = (t == 0) ? 8'h00 : (t == 1) ? 8'hff : 8'($random(seed));
            d2 = 2'($random(seed));
            stat_mem_select = 1'b1;
            // Write then read the same entry back to back
            @(negedge clk);
            hpp_addr = {10'h0, i8};
            hpp_wdata = {6'h3f, d2};
            hpp_wr = 1'b1;
            @(negedge clk);
            hpp_wr = 1'b0;
            hpp_rd = 1'b1;
            @(negedge clk);
            hpp_rd = 1'b0;
            chk_out(hpp_rvalid, 36'h1, "status read valid");
            chk_rd(hpp_rdata, {6'h00, d2}, "status read");
            stat_idx = i8;
            @(negedge clk);
            chk_out(stat_value, d2, "core status");
            stat_mem_select = 1'b0;
            wr({10'h0, i8}, {6'h00, ~d2});
            rd({10'h0, i8}, 8'h00, "window closed");
            stat_mem_select = 1'b1;
            rd({10'h0, i8}, {6'h00, d2}, "write ignored");
        end
        $display("test status memory done");
        wr(18'h30928, 8'h5a);
        rd(18'h30928, 8'h00, "unmapped");
        $display("test unmapped done");
        tally_and_finish();
    end
endmodule
